// ==== css_pkg.sv ====
package css_pkg;
   // screen geometry
   localparam logic [6:0] LAST_COL = 7'h49;
   localparam logic [4:0] LAST_ROW = 5'h1A;
   localparam logic [6:0] COL_ZERO = 7'h00;
   localparam logic [4:0] ROW_ZERO = 5'h00;
   // character codes held in the core
   localparam logic [7:0] EOT_CODE = 8'hC0;
   localparam logic [7:0] CR_CODE = 8'h0D;
   localparam int FG_BIT = 7;
   // master timing phase that clocks the read/restore command latch
   localparam logic [2:0] PHASE_RR = 3'h6;
   localparam logic [2:0] PHASE_LAST = 3'h7;
   // routine selection
   typedef enum logic [1:0] {
      CSS_RT_TAB = 2'h0,
      CSS_RT_PRINT = 2'h1,
      CSS_RT_RECORD = 2'h2
   } css_routine_type;
   // sequence steps, one-hot
   typedef enum logic [7:0] {
      CSS_IDLE = 8'h01,
      CSS_S1 = 8'h02,
      CSS_S2 = 8'h04,
      CSS_S3 = 8'h08,
      CSS_S4 = 8'h10,
      CSS_S5 = 8'h20,
      CSS_S6 = 8'h40,
      CSS_S7 = 8'h80
   } css_step_type;
endpackage

// ==== css_sequencer.sv ====
// Notes on behaviour
// - tab step one sets refresh suspend latch, then goes to step two.
// - tab step two reads the cursor cell to learn its foreground flag.
// - foreground and not last cell: advance one column, read again in step two.
// - tab at column 73 row 26 without entry condition stops there.
// - background away from last cell starts background search: read, step five, six.
// - background away from last cell: step seven advances column, loops to four.
// - foreground or last cell ends tab; cursor is the tab stop.
// - print starts on print key with shift or on a remote print request; enters print operation.
// - print step one suspends refresh, goes to step two, clears terminator latch.
// - print steps two and three write terminator ahead and at the cursor.
// - print step four at home requests readout; else step five backs and reads.
// - print step six manages double terminator latch and loops or proceeds.
// - print step seven: latch set repeats and advances; clear moves down, starts readout.
// - record latch sets only with record mode, continuous term and return key.
// - record aborts on background cell, writes return on foreground cell.
// - record step four at home requests readout; else back one and read.
// - record step six loops unless a carriage return was read.
// - record step seven starts readout, moves down to column zero, halts.
// - remote entry runs the same routine as the keyboard would.
// - remote routine's first step clears the remote entry request latch.
// - cursor address, home and intensity commands bypass the sequencer.
// - read/restore is issued when the command latch is clocked at phase six.
// - column increment past 73 carries into the row counter.
`timescale 1ns/10ps
`default_nettype none
module css_sequencer (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic [2:0] i_phase,
   input wire logic i_tab_key,
   input wire logic i_print_key,
   input wire logic i_shift_key,
   input wire logic i_keyboard_return_key,
   input wire logic i_record_mode,
   input wire logic i_continuous_mode_n,
   input wire logic i_alnum_entry,
   input wire logic i_remote_entry,
   input wire logic [1:0] i_remote_routine,
   input wire logic i_remote_address_cursor,
   input wire logic i_remote_home,
   input wire logic i_remote_intensity_bg,
   input wire logic i_remote_intensity_fg,
   input wire logic [6:0] i_remote_col,
   input wire logic [4:0] i_remote_row,
   input wire logic i_mem_done,
   input wire logic [7:0] i_mem_rdata,
   output logic o_busy,
   output logic o_print_mode,
   output logic o_refresh_suspend,
   output logic o_remote_entry_clear,
   output logic o_mem_read,
   output logic o_mem_write,
   output logic [7:0] o_mem_wdata,
   output logic [6:0] o_cursor_col,
   output logic [4:0] o_cursor_row,
   output logic o_start_transmit_readout,
   output logic o_background_intensity,
   output logic o_double_terminator_latch,
   output logic o_keyboard_record_latch
);

   // ----------------------------------------
   // cursor arithmetic
   // ----------------------------------------
   function automatic logic [11:0] step_fwd(input logic [6:0] c, input logic [4:0] r);
      if (c == css_pkg::LAST_COL) begin
         step_fwd = {css_pkg::COL_ZERO, r + 5'h01};
      end else begin
         step_fwd = {c + 7'h01, r};
      end
   endfunction

   function automatic logic [11:0] step_back(input logic [6:0] c, input logic [4:0] r);
      if (c == css_pkg::COL_ZERO) begin
         step_back = {css_pkg::LAST_COL, r - 5'h01};
      end else begin
         step_back = {c - 7'h01, r};
      end
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   css_pkg::css_step_type step_q, step_d;
   css_pkg::css_routine_type rt_q, rt_d;
   logic remote_q, remote_d;
   logic wait_q, wait_d;
   logic rr_pend_q, rr_pend_d;
   logic [7:0] rdata_q, rdata_d;
   logic busy_q, busy_d;
   logic print_mode_q, print_mode_d;
   logic susp_q, susp_d;
   logic rclr_q, rclr_d;
   logic rd_q, rd_d;
   logic wr_q, wr_d;
   logic [7:0] wdata_q, wdata_d;
   logic [6:0] col_q, col_d;
   logic [4:0] row_q, row_d;
   logic start_q, start_d;
   logic bgi_q, bgi_d;
   logic dtl_q, dtl_d;
   logic krl_q, krl_d;

   logic at_last, at_home, is_fg, is_eot, is_cr;
   logic [11:0] fwd, back;

   always_comb begin
      at_last = (col_q == css_pkg::LAST_COL) && (row_q == css_pkg::LAST_ROW);
      at_home = (col_q == css_pkg::COL_ZERO) && (row_q == css_pkg::ROW_ZERO);
      is_fg = rdata_q[css_pkg::FG_BIT];
      is_eot = (rdata_q == css_pkg::EOT_CODE);
      is_cr = (rdata_q[6:0] == css_pkg::CR_CODE[6:0]);
      fwd = step_fwd(col_q, row_q);
      back = step_back(col_q, row_q);
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   // memory requests are single pulses; the step then waits for i_mem_done
   // before sampling data, so memory latency never corrupts a decision.
   always_comb begin
      step_d = step_q;
      rt_d = rt_q;
      remote_d = remote_q;
      wait_d = wait_q;
      rr_pend_d = rr_pend_q;
      rdata_d = rdata_q;
      print_mode_d = print_mode_q;
      susp_d = susp_q;
      rclr_d = 1'b0;
      rd_d = 1'b0;
      wr_d = 1'b0;
      wdata_d = wdata_q;
      col_d = col_q;
      row_d = row_q;
      start_d = 1'b0;
      bgi_d = bgi_q;
      dtl_d = dtl_q;
      krl_d = krl_q;

      // remote commands handled directly, sequencer untouched
      if (step_q == css_pkg::CSS_IDLE) begin
         if (i_remote_address_cursor) begin
            col_d = i_remote_col;
            row_d = i_remote_row;
         end else if (i_remote_home) begin
            col_d = css_pkg::COL_ZERO;
            row_d = css_pkg::ROW_ZERO;
         end else if (i_remote_intensity_bg) begin
            bgi_d = 1'b1;
         end else if (i_remote_intensity_fg) begin
            bgi_d = 1'b0;
         end
      end

      // read/restore latch fires on the t0.6 phase
      if (rr_pend_q && i_phase == css_pkg::PHASE_RR) begin
         rd_d = 1'b1;
         rr_pend_d = 1'b0;
      end
      if (wait_q && i_mem_done) begin
         wait_d = 1'b0;
         rdata_d = i_mem_rdata;
      end

      if (!wait_q && !rr_pend_q && !rd_q && !wr_q) begin
         case (step_q)
            css_pkg::CSS_IDLE: begin
               susp_d = 1'b0;
               if (i_remote_entry) begin
                  rt_d = css_pkg::css_routine_type'(i_remote_routine);
                  remote_d = 1'b1;
                  step_d = css_pkg::CSS_S1;
               end else if (i_print_key && i_shift_key) begin
                  rt_d = css_pkg::CSS_RT_PRINT;
                  remote_d = 1'b0;
                  step_d = css_pkg::CSS_S1;
               end else if (i_tab_key) begin
                  rt_d = css_pkg::CSS_RT_TAB;
                  remote_d = 1'b0;
                  step_d = css_pkg::CSS_S1;
               end else if (i_keyboard_return_key && i_record_mode) begin
                  rt_d = css_pkg::CSS_RT_RECORD;
                  remote_d = 1'b0;
                  step_d = css_pkg::CSS_S1;
               end
            end
            css_pkg::CSS_S1: begin
               if (remote_q) begin
                  rclr_d = 1'b1;
               end
               step_d = css_pkg::CSS_S2;
               case (rt_q)
                  css_pkg::CSS_RT_PRINT: begin
                     susp_d = 1'b1;
                     dtl_d = 1'b0;
                     print_mode_d = 1'b1;
                     wdata_d = css_pkg::EOT_CODE;
                  end
                  css_pkg::CSS_RT_RECORD: begin
                     if (i_record_mode && !i_continuous_mode_n && i_keyboard_return_key) begin
                        krl_d = 1'b1;
                        susp_d = 1'b1;
                     end else begin
                        step_d = css_pkg::CSS_IDLE;
                     end
                  end
                  default: begin
                     susp_d = 1'b1;
                  end
               endcase
            end
            css_pkg::CSS_S2: begin
               if (rt_q == css_pkg::CSS_RT_PRINT) begin
                  {col_d, row_d} = fwd;
                  wr_d = 1'b1;
               end else begin
                  rr_pend_d = 1'b1;
                  wait_d = 1'b1;
               end
               step_d = css_pkg::CSS_S3;
            end
            css_pkg::CSS_S3: begin
               step_d = css_pkg::CSS_S4;
               case (rt_q)
                  css_pkg::CSS_RT_PRINT: begin
                     {col_d, row_d} = back;
                     wr_d = 1'b1;
                  end
                  css_pkg::CSS_RT_RECORD: begin
                     if (!is_fg) begin
                        step_d = css_pkg::CSS_IDLE;
                     end else begin
                        wdata_d = css_pkg::CR_CODE;
                        wr_d = 1'b1;
                     end
                  end
                  default: begin
                     if (is_fg && !at_last) begin
                        {col_d, row_d} = fwd;
                        step_d = css_pkg::CSS_S2;
                     end else if (at_last && !i_alnum_entry) begin
                        step_d = css_pkg::CSS_IDLE;
                     end else if (at_last) begin
                        {col_d, row_d} = fwd;
                        step_d = css_pkg::CSS_IDLE;
                     end
                  end
               endcase
            end
            css_pkg::CSS_S4: begin
               if (rt_q == css_pkg::CSS_RT_TAB) begin
                  rr_pend_d = 1'b1;
                  wait_d = 1'b1;
                  step_d = css_pkg::CSS_S5;
               end else if (at_home) begin
                  start_d = 1'b1;
                  step_d = css_pkg::CSS_IDLE;
               end else begin
                  step_d = css_pkg::CSS_S5;
               end
            end
            css_pkg::CSS_S5: begin
               if (rt_q != css_pkg::CSS_RT_TAB) begin
                  {col_d, row_d} = back;
                  rr_pend_d = 1'b1;
                  wait_d = 1'b1;
               end
               step_d = css_pkg::CSS_S6;
            end
            css_pkg::CSS_S6: begin
               case (rt_q)
                  css_pkg::CSS_RT_PRINT: begin
                     if (!is_eot) begin
                        dtl_d = 1'b0;
                        step_d = css_pkg::CSS_S4;
                     end else if (!dtl_q) begin
                        dtl_d = 1'b1;
                        step_d = css_pkg::CSS_S4;
                     end else begin
                        step_d = css_pkg::CSS_S7;
                     end
                  end
                  css_pkg::CSS_RT_RECORD: begin
                     step_d = is_cr ? css_pkg::CSS_S7 : css_pkg::CSS_S4;
                  end
                  default: begin
                     step_d = (is_fg || at_last) ? css_pkg::CSS_IDLE : css_pkg::CSS_S7;
                  end
               endcase
            end
            css_pkg::CSS_S7: begin
               step_d = css_pkg::CSS_IDLE;
               if (rt_q == css_pkg::CSS_RT_TAB) begin
                  {col_d, row_d} = fwd;
                  step_d = css_pkg::CSS_S4;
               end else if (rt_q == css_pkg::CSS_RT_PRINT && dtl_q) begin
                  dtl_d = 1'b0;
                  {col_d, row_d} = fwd;
                  step_d = css_pkg::CSS_S7;
               end else begin
                  col_d = css_pkg::COL_ZERO;
                  row_d = row_q + 5'h01;
                  start_d = 1'b1;
               end
            end
            default: begin
               step_d = css_pkg::CSS_IDLE;
            end
         endcase
         if (step_d == css_pkg::CSS_IDLE && step_q != css_pkg::CSS_IDLE) begin
            susp_d = 1'b0;
            krl_d = 1'b0;
            print_mode_d = 1'b0;
         end
      end
   end

   always_comb begin
      busy_d = (step_d != css_pkg::CSS_IDLE);
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         step_q <= css_pkg::CSS_IDLE;
         rt_q <= css_pkg::CSS_RT_TAB;
         remote_q <= 1'b0;
         wait_q <= 1'b0;
         rr_pend_q <= 1'b0;
         rdata_q <= 8'h00;
         busy_q <= 1'b0;
         print_mode_q <= 1'b0;
         susp_q <= 1'b0;
         rclr_q <= 1'b0;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         wdata_q <= 8'h00;
         col_q <= 7'h00;
         row_q <= 5'h00;
         start_q <= 1'b0;
         bgi_q <= 1'b0;
         dtl_q <= 1'b0;
         krl_q <= 1'b0;
      end else begin
         step_q <= step_d;
         rt_q <= rt_d;
         remote_q <= remote_d;
         wait_q <= wait_d;
         rr_pend_q <= rr_pend_d;
         rdata_q <= rdata_d;
         busy_q <= busy_d;
         print_mode_q <= print_mode_d;
         susp_q <= susp_d;
         rclr_q <= rclr_d;
         rd_q <= rd_d;
         wr_q <= wr_d;
         wdata_q <= wdata_d;
         col_q <= col_d;
         row_q <= row_d;
         start_q <= start_d;
         bgi_q <= bgi_d;
         dtl_q <= dtl_d;
         krl_q <= krl_d;
      end
   end

   always_comb begin
      o_busy = busy_q;
      o_print_mode = print_mode_q;
      o_refresh_suspend = susp_q;
      o_remote_entry_clear = rclr_q;
      o_mem_read = rd_q;
      o_mem_write = wr_q;
      o_mem_wdata = wdata_q;
      o_cursor_col = col_q;
      o_cursor_row = row_q;
      o_start_transmit_readout = start_q;
      o_background_intensity = bgi_q;
      o_double_terminator_latch = dtl_q;
      o_keyboard_record_latch = krl_q;
   end
endmodule
`default_nettype wire

// ==== css_sequencer_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// port checks on the sequencer
// ------------------------------
module css_sequencer_chk (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic [2:0] i_phase,
   input wire logic i_tab_key,
   input wire logic i_print_key,
   input wire logic i_shift_key,
   input wire logic i_keyboard_return_key,
   input wire logic i_record_mode,
   input wire logic i_continuous_mode_n,
   input wire logic i_remote_entry,
   input wire logic o_busy,
   input wire logic o_print_mode,
   input wire logic o_refresh_suspend,
   input wire logic o_remote_entry_clear,
   input wire logic o_mem_read,
   input wire logic o_mem_write,
   input wire logic [7:0] o_mem_wdata,
   input wire logic [6:0] o_cursor_col,
   input wire logic [4:0] o_cursor_row,
   input wire logic o_start_transmit_readout,
   input wire logic o_double_terminator_latch,
   input wire logic o_keyboard_record_latch
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rstn);
   a_read_on_phase: assert property (o_mem_read |-> $past(i_phase) == css_pkg::PHASE_RR)
      else $error("read issued off its phase");
   a_busy_has_cause: assert property (
      $rose(o_busy) |-> $past(i_tab_key || (i_print_key && i_shift_key) || i_remote_entry
         || (i_keyboard_return_key && i_record_mode)))
      else $error("routine started without a request");
   a_suspend_on_tab: assert property (
      $rose(o_busy) && $past(i_tab_key && !i_remote_entry && !i_print_key && !i_keyboard_return_key)
         |-> ##[0:2] o_refresh_suspend)
      else $error("tab did not suspend refresh");
   a_record_latch_cause: assert property (
      $rose(o_keyboard_record_latch) |-> $past(i_record_mode && !i_continuous_mode_n && i_keyboard_return_key))
      else $error("record latch set without its terms");
   a_print_entry_state: assert property (
      $rose(o_print_mode) |-> o_refresh_suspend && !o_double_terminator_latch
         && o_mem_wdata == css_pkg::EOT_CODE)
      else $error("print step one left suspend, latch or write data wrong");
   a_remote_clear_busy: assert property (o_remote_entry_clear |-> o_busy && i_remote_entry)
      else $error("remote clear outside a remote routine");
   a_print_writes_eot: assert property (
      o_mem_write && o_print_mode |-> o_mem_wdata == css_pkg::EOT_CODE)
      else $error("print wrote a code other than the terminator");
   a_readout_ends_run: assert property ($rose(o_start_transmit_readout) |-> ##[0:3] !o_busy)
      else $error("sequencer kept running after readout");
   a_cursor_on_screen: assert property (
      o_cursor_col <= css_pkg::LAST_COL && o_cursor_row <= css_pkg::LAST_ROW)
      else $error("cursor left the screen");
endmodule
bind css_sequencer css_sequencer_chk i_css_sequencer_chk (.*);
`default_nettype wire

// ==== css_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// core memory and phase source
// ------------------------------
module css_mem_model (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_mem_read,
   input wire logic i_mem_write,
   input wire logic [7:0] i_mem_wdata,
   input wire logic [6:0] i_col,
   input wire logic [4:0] i_row,
   output var logic [2:0] o_phase = 3'h0,
   output var logic o_mem_done = 1'b0,
   output var logic [7:0] o_mem_rdata = 8'h00
);
   logic [7:0] mem [0:4095];
   logic [7:0] rd_q;
   int wait_q;
   // answer delay varies so the sequencer must really wait for done
   always @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_phase <= 3'h0;
         o_mem_done <= 1'b0;
         wait_q <= 0;
      end else begin
         o_phase <= o_phase + 3'h1;
         o_mem_done <= 1'b0;
         // data is only valid with done, so it keeps moving otherwise
         o_mem_rdata <= ~o_mem_rdata;
         if (i_mem_write) mem[{i_row, i_col}] <= i_mem_wdata;
         if (i_mem_read) begin
            rd_q <= mem[{i_row, i_col}];
            wait_q <= 1 + int'($urandom % 3);
         end else if (wait_q == 1) begin
            o_mem_done <= 1'b1;
            o_mem_rdata <= rd_q;
            wait_q <= 0;
         end else if (wait_q > 1) wait_q <= wait_q - 1;
      end
   end
endmodule
`default_nettype wire

// ==== cursor_search_sequencer_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
// ------------------------------
// sequencer routines end to end
// ------------------------------
module cursor_search_sequencer_tb;
   logic i_sys_clk = 1'b0, i_rstn = 1'b0, i_tab_key = 1'b0, i_print_key = 1'b0, i_shift_key = 1'b0;
   logic i_keyboard_return_key = 1'b0, i_record_mode = 1'b0, i_continuous_mode_n = 1'b1, i_alnum_entry = 1'b0;
   logic i_remote_entry = 1'b0, i_remote_address_cursor = 1'b0, i_remote_home = 1'b0;
   logic i_remote_intensity_bg = 1'b0, i_remote_intensity_fg = 1'b0, i_mem_done, o_busy, o_print_mode;
   logic [1:0] i_remote_routine = 2'h0;
   logic [6:0] i_remote_col = 7'h00, o_cursor_col;
   logic [4:0] i_remote_row = 5'h00, o_cursor_row;
   logic [2:0] i_phase;
   logic [7:0] i_mem_rdata, o_mem_wdata;
   logic o_refresh_suspend, o_remote_entry_clear, o_mem_read, o_mem_write, o_start_transmit_readout;
   logic o_background_intensity, o_double_terminator_latch, o_keyboard_record_latch;
   logic [12:0] exp_q [$];
   logic [12:0] e;
   logic [7:0] eot = css_pkg::EOT_CODE;
   logic pm_seen = 1'b0;
   int errors = 0, cmp_count = 0, rd_cnt = 0, n;
   always #2.5 i_sys_clk = ~i_sys_clk;
   css_sequencer i_css_sequencer (.*);
   css_mem_model i_css_mem_model (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_mem_read(o_mem_read),
      .i_mem_write(o_mem_write), .i_mem_wdata(o_mem_wdata), .i_col(o_cursor_col), .i_row(o_cursor_row),
      .o_phase(i_phase), .o_mem_done(i_mem_done), .o_mem_rdata(i_mem_rdata));
   task automatic step(input int k);
      repeat (k) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic report_and_stop();
      $display("errors=%0d comparisons=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic put(input int c, input int r, input logic [7:0] v);
      i_css_mem_model.mem[r * 128 + c] = v;
   endtask
   function automatic logic [7:0] get(input int c, input int r);
      return i_css_mem_model.mem[r * 128 + c];
   endfunction
   // fillers never match a terminator or a return, not even in the low seven bits
   task automatic fill();
      for (int i = 0; i < 4096; i++) i_css_mem_model.mem[i] = 8'h90 | 8'($urandom % 48);
   endtask
   function automatic logic [7:0] bgv();
      return 8'h20 | 8'($urandom % 32);
   endfunction
   task automatic place(input int c, input int r);
      i_remote_col = 7'(c);
      i_remote_row = 5'(r);
      i_remote_address_cursor = 1'b1;
      step(1);
      i_remote_address_cursor = 1'b0;
      step(2);
      `CHK({o_busy, o_cursor_row, o_cursor_col}, {1'b0, 5'(r), 7'(c)})
   endtask
   // k: 0 tab, 1 print with shift, 2 return key, 3 remote request
   task automatic go(input int k, input int c, input int r, input logic ro);
      exp_q.push_back({ro, 5'(r), 7'(c)});
      i_tab_key = (k == 0);
      i_print_key = (k == 1);
      i_shift_key = (k == 1);
      i_keyboard_return_key = (k == 2);
      i_remote_entry = (k == 3);
      for (n = 0; n < 50 && ((k == 3) ? o_remote_entry_clear !== 1'b1 : o_busy !== 1'b1); n++) step(1);
      // keep the keys one more edge: record step one looks at the return key again
      step(1);
      {i_tab_key, i_print_key, i_shift_key, i_keyboard_return_key, i_remote_entry} = 5'h00;
      if (n == 50) begin
         errors++;
         report_and_stop();
      end
      for (n = 0; n < 5000 && o_busy !== 1'b0; n++) step(1);
      if (n == 5000) begin
         errors++;
         report_and_stop();
      end
      step(4);
   endtask
   always @(posedge i_sys_clk) begin
      if (o_start_transmit_readout === 1'b1) rd_cnt++;
      if (o_print_mode === 1'b1) pm_seen = 1'b1;
   end
   initial begin
      wait (i_rstn === 1'b1);
      forever begin
         @(negedge o_busy);
         step(2);
         `CHK(exp_q.size() > 0, 1'b1)
         if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            `CHK({rd_cnt != 0, o_cursor_row, o_cursor_col}, e)
         end
         rd_cnt = 0;
      end
   end
   initial begin
      n = $urandom(26506);
      step(20);
      i_rstn = 1'b1;
      step(2);
      fill();
      place(72, 1);
      for (int c = 0; c < 3; c++) put(c, 2, bgv());
      go(0, 3, 2, 1'b0);
      place(70, 26);
      go(0, 73, 26, 1'b0);
      place(10, 5);
      put(11, 5, bgv());
      i_remote_routine = css_pkg::CSS_RT_TAB;
      go(3, 12, 5, 1'b0);
      i_remote_home = 1'b1;
      step(1);
      i_remote_home = 1'b0;
      i_remote_intensity_bg = 1'b1;
      step(1);
      i_remote_intensity_bg = 1'b0;
      step(2);
      `CHK({o_busy, o_background_intensity, o_cursor_row, o_cursor_col}, 14'h1000)
      i_remote_intensity_fg = 1'b1;
      step(1);
      i_remote_intensity_fg = 1'b0;
      step(2);
      `CHK(o_background_intensity, 1'b0)
      i_record_mode = 1'b1;
      i_continuous_mode_n = 1'b0;
      fill();
      place(0, 4);
      put(70, 3, css_pkg::CR_CODE);
      go(2, 0, 4, 1'b1);
      `CHK(get(0, 4), css_pkg::CR_CODE)
      place(2, 0);
      go(2, 0, 0, 1'b1);
      place(5, 5);
      put(5, 5, bgv());
      go(2, 5, 5, 1'b0);
      i_continuous_mode_n = 1'b1;
      go(2, 5, 5, 1'b0);
      `CHK(o_keyboard_record_latch, 1'b0)
      i_record_mode = 1'b0;
      i_rstn = 1'b0;
      step(2);
      i_rstn = 1'b1;
      step(2);
      i_print_key = 1'b1;
      step(6);
      `CHK({o_busy, pm_seen}, 2'b00)
      i_print_key = 1'b0;
      fill();
      place(20, 2);
      put(15, 2, eot);
      put(11, 2, eot);
      put(10, 2, eot);
      go(1, 0, 3, 1'b1);
      `CHK({get(21, 2), get(20, 2), pm_seen}, {eot, eot, 1'b1})
      place(0, 0);
      go(1, 0, 0, 1'b1);
      `CHK(exp_q.size(), 0)
      report_and_stop();
   end
endmodule
`default_nettype wire
